// file: down_timer.sv
// Reloading down counter that pulses once per period
`timescale 1ns/100ps
module down_timer
  import protect_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [31:0] period,
  // Status
  output logic [31:0] count,
  output logic expire
);

  typedef struct packed {
    logic [31:0] count;
    logic expire;
  } timerState_t;

  timerState_t state;
  timerState_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Restart has priority so a service never loses to an expiry
  always_comb begin
    next_state = state;
    next_state.expire = 1'b0;
    if (restart) begin
      next_state.count = period;
    end else if (run) begin
      if (state.count <= 32'h00000001) begin
        next_state.expire = 1'b1;
        next_state.count = period;
      end else begin
        next_state.count = state.count - 32'h00000001;
      end
    end
  end

  // Starts at the largest count until the owner restarts it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{count: 32'hFFFFFFFF, expire: 1'b0};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign count = state.count;
  assign expire = state.expire;

endmodule

// file: protect_pkg.sv
// Constants and types shared by the system protection timers
package protect_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time
  localparam int CLK_PERIOD_NS = 40;
  // Longest watchdog period, about one second; rounded down to cycles
  localparam int WDOG_MAX_NS = 1_000_000_000;
  localparam int WDOG_MAX_CYCLES = WDOG_MAX_NS / CLK_PERIOD_NS;
  // One periodic unit, 4000 ticks of a 32.768 kHz source; rounded up
  localparam int PIT_UNIT_NS = 122_070_000;
  localparam int PIT_UNIT_CYCLES = (PIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Largest unit count, giving about 15.9 s
  localparam logic [7:0] PIT_MAX_COUNT = 8'h82;
  localparam logic [2:0] WDOG_SEL_MAX = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] OFS_PROT_CTRL = 5'h00;
  localparam logic [4:0] OFS_SERVICE = 5'h04;
  localparam logic [4:0] OFS_PIT_CTRL = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_IRQ_EN = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
  localparam logic [4:0] OFS_WDOG_COUNT = 5'h18;

  // protection_control_reg fields
  localparam int PC_SEL_LSB = 0;
  localparam int PC_EN_BIT = 3;
  localparam int PC_IRQMODE_BIT = 4;
  localparam int PC_WDOG_FRZ_BIT = 5;
  localparam int PC_PIT_FRZ_BIT = 6;
  localparam int PC_LOCK_BIT = 31;
  localparam logic [31:0] PROT_CTRL_RESET = 32'h0000006F;

  // Periodic control fields
  localparam int PIT_COUNT_LSB = 0;
  localparam int PIT_EN_BIT = 8;
  localparam logic [31:0] PIT_CTRL_RESET = 32'h00000000;

  // Status, enable and clear bits share one layout
  localparam int ST_WDOG = 0;
  localparam int ST_PIT = 1;
  localparam int ST_SPUR = 2;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;

  // Service keys, written in this order
  localparam logic [7:0] SERVICE_KEY1 = 8'h55;
  localparam logic [7:0] SERVICE_KEY2 = 8'hAA;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } busState_t;

  typedef enum logic [1:0] {
    SVC_IDLE = 2'b01,
    SVC_ARMED = 2'b10
  } svcState_t;

endpackage

// file: spurious_monitor.sv
// Ends an interrupt acknowledge cycle that no source answers
`timescale 1ns/100ps
module spurious_monitor
  import protect_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Acknowledge cycle
  input wire logic iackActive,
  input wire logic arbHit,
  input wire logic arbDone,
  // Results
  output logic busError,
  output logic spuriousEvent
);

  typedef struct packed {
    logic hit;
    logic busErr;
    logic evt;
  } spurState_t;

  spurState_t state;
  spurState_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Bus error holds until the cycle is dropped by the core
  always_comb begin
    next_state = state;
    next_state.evt = 1'b0;
    if (!iackActive) begin
      next_state.hit = 1'b0;
      next_state.busErr = 1'b0;
    end else begin
      if (arbHit) begin
        next_state.hit = 1'b1;
      end
      if (arbDone && !state.hit && !arbHit && !state.busErr) begin
        next_state.busErr = 1'b1;
        next_state.evt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{hit: 1'b0, busErr: 1'b0, evt: 1'b0};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign busError = state.busErr;
  assign spuriousEvent = state.evt;

endmodule

// file: system_protection_timers.sv
// Watchdog, periodic timer and spurious interrupt monitor with Avalon-MM registers
//
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps

// Behaviour
// - Watchdog expiry gives reset or level-7 interrupt
// - Eight selectable watchdog timeout periods
// - After reset: enabled, about 1 s, reset
// - Control register writable once per reset
// - Unanswered acknowledge cycle raises bus error
// - Periodic interrupt, programmable 122 ms to 15.87 s
// - Disabled periodic timer raises no interrupts
// - Freeze may halt each timer separately
module system_protection_timers
  import protect_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_MAX_CYCLES,
  parameter int PIT_CYCLES = PIT_UNIT_CYCLES
)
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Freeze mode
  input wire logic freeze,
  // Interrupt acknowledge cycle
  input wire logic iackActive,
  input wire logic arbHit,
  input wire logic arbDone,
  // Results
  output logic busError,
  output logic sysResetReq,
  output logic level7Irq,
  output logic irq
);

  typedef struct packed {
    busState_t bus;
    logic waitReq;
    logic [31:0] rdata;
    logic ctrlLocked;
    logic [2:0] wdogSel;
    logic wdogEn;
    logic wdogIrqMode;
    logic wdogFrz;
    logic pitFrz;
    svcState_t svc;
    logic wdogRestart;
    logic [7:0] pitCount;
    logic pitEn;
    logic pitRestart;
    logic [2:0] status;
    logic [2:0] irqEnable;
    logic irq;
    logic level7;
    logic resetReq;
  } regs_t;

  regs_t state;
  regs_t next_state;

  logic wdogRun;
  logic wdogExpire;
  logic [31:0] wdogCount;
  logic pitRun;
  logic pitExpire;
  logic spuriousEvent;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte lanes written by the current access
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Merge write data into an old value on the enabled lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    return (old & ~laneMask(be)) | (wd & laneMask(be));
  endfunction

  // Shortest period doubles for each selector step
  function automatic logic [31:0] wdogPeriod(input logic [2:0] sel);
    return 32'(WDOG_CYCLES) >> (WDOG_SEL_MAX - sel);
  endfunction

  // Zero acts as one unit, large counts clamp to the longest period
  function automatic logic [31:0] pitPeriod(input logic [7:0] cnt);
    logic [7:0] c;
    c = cnt;
    if (c == 8'h00) begin
      c = 8'h01;
    end else if (c > PIT_MAX_COUNT) begin
      c = PIT_MAX_COUNT;
    end
    return 32'(c) * 32'(PIT_CYCLES);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timers halt in freeze only when configured to
  assign wdogRun = state.wdogEn && !(freeze && state.wdogFrz);
  assign pitRun = state.pitEn && !(freeze && state.pitFrz);

  down_timer wdogTimer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(wdogRun),
    .restart(state.wdogRestart),
    .period(wdogPeriod(state.wdogSel)),
    .count(wdogCount),
    .expire(wdogExpire)
  );

  down_timer pitTimer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .run(pitRun),
    .restart(state.pitRestart),
    .period(pitPeriod(state.pitCount)),
    .count(),
    .expire(pitExpire)
  );

  spurious_monitor spurMon (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .iackActive(iackActive),
    .arbHit(arbHit),
    .arbDone(arbDone),
    .busError(busError),
    .spuriousEvent(spuriousEvent)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, control registers, events
  always_comb begin
    logic [31:0] wd;
    logic [31:0] ctrlNew;
    logic [31:0] pitNew;
    logic [2:0] clearBits;
    logic [2:0] events;
    logic doWrite;
    wd = avs_writedata & laneMask(avs_byteenable);
    ctrlNew = 32'h00000000;
    pitNew = 32'h00000000;
    clearBits = 3'h0;
    events = 3'h0;
    doWrite = 1'b0;
    next_state = state;
    next_state.wdogRestart = 1'b0;
    next_state.pitRestart = 1'b0;

    // Bus: one wait cycle, the access completes on the edge after
    case (state.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_state.bus = BUS_ACK;
          next_state.waitReq = 1'b0;
          next_state.rdata = 32'h00000000;
          if (avs_read) begin
            case (avs_address)
              OFS_PROT_CTRL: begin
                next_state.rdata[PC_SEL_LSB +: 3] = state.wdogSel;
                next_state.rdata[PC_EN_BIT] = state.wdogEn;
                next_state.rdata[PC_IRQMODE_BIT] = state.wdogIrqMode;
                next_state.rdata[PC_WDOG_FRZ_BIT] = state.wdogFrz;
                next_state.rdata[PC_PIT_FRZ_BIT] = state.pitFrz;
                next_state.rdata[PC_LOCK_BIT] = state.ctrlLocked;
              end
              OFS_PIT_CTRL: begin
                next_state.rdata[PIT_COUNT_LSB +: 8] = state.pitCount;
                next_state.rdata[PIT_EN_BIT] = state.pitEn;
              end
              OFS_STATUS: begin
                next_state.rdata[2:0] = state.status;
              end
              OFS_IRQ_EN: begin
                next_state.rdata[2:0] = state.irqEnable;
              end
              OFS_WDOG_COUNT: begin
                next_state.rdata = wdogCount;
              end
              default: begin
                next_state.rdata = 32'h00000000;
              end
            endcase
          end
        end
      end
      BUS_ACK: begin
        next_state.bus = BUS_IDLE;
        next_state.waitReq = 1'b1;
        doWrite = avs_write;
      end
      default: begin
        next_state.bus = BUS_IDLE;
        next_state.waitReq = 1'b1;
      end
    endcase

    // Register writes, taken on the completing edge
    if (doWrite) begin
      case (avs_address)
        OFS_PROT_CTRL: begin
          // Later writes are dropped so runaway code cannot disarm it
          if (!state.ctrlLocked) begin
            ctrlNew = merge({24'h000000, 1'b0, state.pitFrz, state.wdogFrz,
                             state.wdogIrqMode, state.wdogEn, state.wdogSel},
                            avs_writedata, avs_byteenable);
            next_state.wdogSel = ctrlNew[PC_SEL_LSB +: 3];
            next_state.wdogEn = ctrlNew[PC_EN_BIT];
            next_state.wdogIrqMode = ctrlNew[PC_IRQMODE_BIT];
            next_state.wdogFrz = ctrlNew[PC_WDOG_FRZ_BIT];
            next_state.pitFrz = ctrlNew[PC_PIT_FRZ_BIT];
            next_state.ctrlLocked = 1'b1;
            next_state.wdogRestart = 1'b1;
          end
        end
        OFS_SERVICE: begin
          // Two-key sequence; any value other than the two keys disarms
          case (state.svc)
            SVC_IDLE: begin
              if (wd[7:0] == SERVICE_KEY1) begin
                next_state.svc = SVC_ARMED;
              end
            end
            SVC_ARMED: begin
              if (wd[7:0] == SERVICE_KEY2) begin
                next_state.wdogRestart = 1'b1;
                next_state.svc = SVC_IDLE;
              end else if (wd[7:0] != SERVICE_KEY1) begin
                next_state.svc = SVC_IDLE;
              end
            end
            default: begin
              next_state.svc = SVC_IDLE;
            end
          endcase
        end
        OFS_PIT_CTRL: begin
          pitNew = merge({23'h000000, state.pitEn, state.pitCount},
                         avs_writedata, avs_byteenable);
          next_state.pitCount = pitNew[PIT_COUNT_LSB +: 8];
          next_state.pitEn = pitNew[PIT_EN_BIT];
          next_state.pitRestart = 1'b1;
        end
        OFS_IRQ_EN: begin
          next_state.irqEnable = wd[2:0];
        end
        OFS_IRQ_CLR: begin
          clearBits = wd[2:0];
        end
        default: begin
          clearBits = 3'h0;
        end
      endcase
    end

    // Watchdog expiry goes to reset or to the level-7 request
    if (wdogExpire) begin
      if (state.wdogIrqMode) begin
        events[ST_WDOG] = 1'b1;
      end else begin
        next_state.resetReq = 1'b1;
      end
    end
    events[ST_PIT] = pitExpire && state.pitEn;
    events[ST_SPUR] = spuriousEvent;

    // A new event wins over a clear in the same cycle
    next_state.status = (state.status & ~clearBits) | events;
    next_state.level7 = next_state.status[ST_WDOG];
    next_state.irq = |(next_state.status & next_state.irqEnable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset leaves the watchdog armed at its longest period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '{
        bus: BUS_IDLE,
        waitReq: 1'b1,
        rdata: 32'h00000000,
        ctrlLocked: 1'b0,
        wdogSel: PROT_CTRL_RESET[PC_SEL_LSB +: 3],
        wdogEn: PROT_CTRL_RESET[PC_EN_BIT],
        wdogIrqMode: PROT_CTRL_RESET[PC_IRQMODE_BIT],
        wdogFrz: PROT_CTRL_RESET[PC_WDOG_FRZ_BIT],
        pitFrz: PROT_CTRL_RESET[PC_PIT_FRZ_BIT],
        svc: SVC_IDLE,
        wdogRestart: 1'b1,
        pitCount: PIT_CTRL_RESET[PIT_COUNT_LSB +: 8],
        pitEn: PIT_CTRL_RESET[PIT_EN_BIT],
        pitRestart: 1'b1,
        status: 3'h0,
        irqEnable: IRQ_EN_RESET,
        irq: 1'b0,
        level7: 1'b0,
        resetReq: 1'b0
      };
    end else if (ce) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign avs_readdata = state.rdata;
  assign avs_waitrequest = state.waitReq;
  assign sysResetReq = state.resetReq;
  assign level7Irq = state.level7;
  assign irq = state.irq;

endmodule

// file: system_protection_timers_properties.sv
// Port checker for the system protection timers, bound to the top module
`timescale 1ns/100ps
module protect_checker #(
  parameter int WDOG_CYCLES = 1024
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Freeze and acknowledge cycle
  input wire logic freeze,
  input wire logic iackActive,
  input wire logic arbHit,
  input wire logic arbDone,
  // Results
  input wire logic busError,
  input wire logic sysResetReq,
  input wire logic level7Irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic hitSeen;
  logic touched;
  int quiet;
  ////////////////////////////////////////////////////////////////////////////
  // Hit memory per acknowledge cycle; run time counted only while unfrozen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hitSeen <= 1'b0;
      touched <= 1'b0;
      quiet <= 0;
    end else begin
      hitSeen <= iackActive && (hitSeen || arbHit);
      touched <= touched || avs_write;
      if (ce && !freeze) quiet <= quiet + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_waitOne; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_waitAns; (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest;
  endproperty
  property p_rstSticky; sysResetReq |=> sysResetReq; endproperty
  property p_wdogEarly; !touched && quiet < WDOG_CYCLES - 6 |-> !sysResetReq; endproperty
  property p_wdogLate; !touched && quiet == WDOG_CYCLES + 6 |-> sysResetReq; endproperty
  property p_berrSet; iackActive && arbDone && !arbHit && !hitSeen && ce |=> busError;
  endproperty
  property p_berrCause;
    $rose(busError) |-> $past(iackActive) && $past(arbDone) && !$past(arbHit);
  endproperty
  property p_berrHold; busError && iackActive |=> busError; endproperty
  property p_berrDrop; busError && !iackActive && ce |=> !busError; endproperty
  a_waitOne: assert property (p_waitOne) else $error("waitrequest low too long");
  a_waitAns: assert property (p_waitAns) else $error("request not answered");
  a_rstSticky: assert property (p_rstSticky) else $error("reset request dropped");
  a_wdogEarly: assert property (p_wdogEarly) else $error("watchdog fired early");
  a_wdogLate: assert property (p_wdogLate) else $error("watchdog did not fire");
  a_berrSet: assert property (p_berrSet) else $error("no bus error");
  a_berrCause: assert property (p_berrCause) else $error("bus error without cause");
  a_berrHold: assert property (p_berrHold) else $error("bus error dropped early");
  a_berrDrop: assert property (p_berrDrop) else $error("bus error stuck");
  // Main scenarios reached
  c_berr: cover property ($rose(busError));
  c_reset: cover property ($rose(sysResetReq));
  c_lvl7: cover property ($rose(level7Irq));
endmodule

bind system_protection_timers protect_checker #(.WDOG_CYCLES(WDOG_CYCLES)) chk_u (
  .clk(clk), .rst(rst), .ce(ce), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .freeze(freeze), .iackActive(iackActive),
  .arbHit(arbHit), .arbDone(arbDone), .busError(busError), .sysResetReq(sysResetReq),
  .level7Irq(level7Irq));

// file: testbench.sv
// Self-checking testbench for the system protection timers
`timescale 1ns/100ps
module testbench;
  import protect_pkg::*;
  typedef struct packed {logic wr; logic [4:0] a; logic [31:0] v;} row_t;
  logic clk = 0, rst = 1, ce = 1, avs_read = 0, avs_write = 0, freeze = 0;
  logic [4:0] avs_address = 5'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, iackActive = 0, arbHit = 0, arbDone = 0;
  logic busError, sysResetReq, level7Irq, irq;
  int failCount = 0, comparisons = 0, cycles = 0, n, p;
  // Reads after reset, then write-once locking; v is write data or expected read
  // The last row reads the count that a disabled watchdog holds after its reload
  row_t rows[15] = '{'{0, OFS_PROT_CTRL, 32'h6F}, '{0, OFS_PIT_CTRL, 0}, '{0, OFS_IRQ_EN, 0},
    '{0, OFS_STATUS, 0}, '{0, 5'h1C, 0}, '{1, 5'h1C, 32'hFFFFFFFF}, '{0, 5'h1C, 0},
    '{1, OFS_PROT_CTRL, 32'h07}, '{0, OFS_PROT_CTRL, 32'h80000007},
    '{1, OFS_PROT_CTRL, 32'h18}, '{0, OFS_PROT_CTRL, 32'h80000007},
    '{0, OFS_SERVICE, 0}, '{1, OFS_IRQ_EN, 32'h7}, '{0, OFS_IRQ_EN, 32'h7},
    '{0, OFS_WDOG_COUNT, 32'h400}};
  logic [7:0] pitCnt[4] = '{8'h00, 8'h01, 8'h82, 8'h01};

  system_protection_timers #(.WDOG_CYCLES(1024), .PIT_CYCLES(10)) dut_u (.clk, .rst, .ce,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .freeze, .iackActive, .arbHit, .arbDone, .busError, .sysResetReq,
    .level7Irq, .irq);

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock; the cycle ceiling cuts a hang short
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      finishTest();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Cycles until reset request (0), level-7 (1) or irq (2) is seen high
  task automatic await(input int s, input int lim);
    n = 0;
    while (n < lim && !(s == 0 ? sysResetReq === 1'b1 : s == 1 ? level7Irq === 1'b1
        : irq === 1'b1)) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    doReset();
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].v);
      if (!rows[i].wr) check("reg row", q, rows[i].v);
    end
    await(0, 1100);
    check("disabled wdog", sysResetReq, 1'b0);
    $display("register rows done");
    // Default watchdog, held off by freeze for 200 cycles
    freeze <= 1'b1;
    doReset();
    repeat (200) @(posedge clk);
    freeze <= 1'b0;
    await(0, 1100);
    check("default expiry", n >= 1024 && n <= 1028, 1'b1);
    $display("default watchdog done");
    // Every period in interrupt mode
    for (int s = 0; s < 8; s++) begin
      doReset();
      bus(1'b1, OFS_PROT_CTRL, 32'h18 | s);
      p = 1024 >> (7 - s);
      await(1, 1100);
      check("wdog period", n >= p && n <= p + 4, 1'b1);
      check("no reset req", sysResetReq, 1'b0);
    end
    $display("periods done");
    // Service restarts a full period; then mask, enable and clear
    doReset();
    bus(1'b1, OFS_PROT_CTRL, 32'h1F);
    repeat (600) @(posedge clk);
    bus(1'b1, OFS_SERVICE, {24'h0, SERVICE_KEY1});
    bus(1'b1, OFS_SERVICE, {24'h0, SERVICE_KEY2});
    await(1, 1100);
    check("serviced period", n >= 1024 && n <= 1028, 1'b1);
    check("masked irq", irq, 1'b0);
    bus(1'b0, OFS_STATUS, 0);
    check("status wdog", q, 32'h1);
    bus(1'b1, OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk);
    check("enabled irq", irq, 1'b1);
    bus(1'b1, OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    check("cleared lvl7", {level7Irq, irq}, 2'b00);
    $display("service and interrupt done");
    // Periodic timer: count zero, minimum, maximum, and freeze
    doReset();
    bus(1'b1, OFS_PROT_CTRL, 32'h40);
    bus(1'b1, OFS_IRQ_EN, 32'h2);
    foreach (pitCnt[i]) begin
      bus(1'b1, OFS_PIT_CTRL, {23'h0, 1'b1, pitCnt[i]});
      // Only the last row freezes; a tick that slips through shows up as n of 0
      if (i == 3) begin
        freeze <= 1'b1;
        repeat (30) @(posedge clk);
        freeze <= 1'b0;
      end
      p = (pitCnt[i] == 0 ? 1 : pitCnt[i]) * 10;
      await(2, 1400);
      check("tick period", n >= p && n <= p + 4, 1'b1);
      bus(1'b1, OFS_IRQ_CLR, 32'h2);
    end
    bus(1'b1, OFS_PIT_CTRL, 32'h001);
    bus(1'b1, OFS_IRQ_CLR, 32'h2);
    repeat (100) @(posedge clk);
    check("pit disabled", irq, 1'b0);
    $display("periodic done");
    // Unanswered acknowledge cycle, then one answered by a source
    bus(1'b1, OFS_IRQ_EN, 32'h4);
    iackActive <= 1'b1;
    @(posedge clk);
    arbDone <= 1'b1;
    @(posedge clk);
    arbDone <= 1'b0;
    @(posedge clk);
    check("bus error", busError, 1'b1);
    repeat (2) @(posedge clk);
    check("spurious irq", irq, 1'b1);
    iackActive <= 1'b0;
    repeat (2) @(posedge clk);
    check("bus error end", busError, 1'b0);
    iackActive <= 1'b1;
    arbHit <= 1'b1;
    @(posedge clk);
    arbHit <= 1'b0;
    arbDone <= 1'b1;
    @(posedge clk);
    arbDone <= 1'b0;
    repeat (2) @(posedge clk);
    check("answered iack", busError, 1'b0);
    iackActive <= 1'b0;
    bus(1'b0, OFS_STATUS, 0);
    check("status spurious", q, 32'h4);
    $display("spurious done");
    finishTest();
  end
endmodule
